// ---- rtl/sbr_pkg.sv ----
// Purpose: shared constants and helpers of the serial block register link
// Assumes: 16-bit words, 5-byte fixed blocks, big-endian words
// Notes:   error code values and area sizes are plain local choices
package sbr_pkg;
   // ==========================================================
   // Command and status codes
   localparam logic [7:0] CMD_NOP         = 8'h00;
   localparam logic [7:0] CMD_RD_WORD     = 8'h10;
   localparam logic [7:0] CMD_RD_BULK     = 8'h20;
   localparam logic [7:0] CMD_XCHG        = 8'h40;
   localparam logic [7:0] ST_NONE         = 8'h00;
   localparam logic [7:0] ST_FETCH_OK     = 8'h01;
   localparam logic [7:0] ST_FETCH_FAILED = 8'h02;
   localparam logic [7:0] ST_XCHG_OK      = 8'h10;
   localparam logic [7:0] ST_XCHG_FAILED  = 8'h20;
   // Values are arbitrary
   localparam logic [15:0] ERR_ADDR       = 16'h0001;
   localparam logic [15:0] ERR_LEN        = 16'h0002;
   localparam logic [15:0] ERR_ACCESS     = 16'h0003;
   localparam logic [15:0] ERR_NONE       = 16'h0000;

   // ==========================================================
   // Block and area layout
   localparam int          FIX_BYTES      = 5;
   localparam int          MEM_WORDS      = 320;
   localparam logic [15:0] GEN_WORDS      = 16'h0040;
   localparam logic [15:0] OUT_BASE       = 16'h1001;
   localparam logic [15:0] IN_BASE        = 16'h2001;
   localparam logic [15:0] AREA_WORDS     = 16'h0080;
   localparam logic [15:0] OUT_END        = OUT_BASE + AREA_WORDS;
   localparam logic [15:0] IN_END         = IN_BASE + AREA_WORDS;
   localparam logic [15:0] OUT_IDX        = 16'h0040;
   localparam logic [15:0] IN_IDX         = 16'h00C0;
   localparam logic [15:0] MAX_CHAIN      = 16'h0080;
   localparam logic [15:0] MAX_OTHER      = 16'h0010;

   // ==========================================================
   // Link timing
   localparam int          CLK_NS         = 4;
   localparam int          SCLK_HALF_NS   = 16;
   localparam logic [2:0]  HALF_CYC       = 3'(SCLK_HALF_NS / CLK_NS);

   typedef enum logic {PH_FIX, PH_VAR} sbr_phase_t;

   // Address to {valid, word index}
   function automatic logic [9:0] addr_map(input logic [15:0] a);
      logic [15:0] o;
      o = 16'h0000;
      addr_map = 10'h000;
      if (a < GEN_WORDS) begin
         addr_map = {1'b1, a[8:0]};
      end else if (a >= OUT_BASE && a < OUT_END) begin
         o = a - OUT_BASE + OUT_IDX;
         addr_map = {1'b1, o[8:0]};
      end else if (a >= IN_BASE && a < IN_END) begin
         o = a - IN_BASE + IN_IDX;
         addr_map = {1'b1, o[8:0]};
      end
   endfunction : addr_map

   // Word count legal for this bulk command
   function automatic logic lim_ok(input logic [7:0] c, input logic [15:0] a, input logic [15:0] n);
      logic [15:0] lim;
      lim = MAX_OTHER;
      if (c == CMD_XCHG || (a >= OUT_BASE && a < OUT_END)) lim = MAX_CHAIN;
      lim_ok = (n != 16'h0000) && (n <= lim);
   endfunction : lim_ok

   // Byte k of a 5-byte block: code, two words high byte first
   function automatic logic [7:0] fix_byte(input logic [2:0] k, input logic [7:0] s,
                                           input logic [15:0] w1, input logic [15:0] w2);
      case (k)
         3'd0:    fix_byte = s;
         3'd1:    fix_byte = w1[15:8];
         3'd2:    fix_byte = w1[7:0];
         3'd3:    fix_byte = w2[15:8];
         default: fix_byte = w2[7:0];
      endcase
   endfunction : fix_byte
endpackage : sbr_pkg

// ---- rtl/sbr_link_if.sv ----
// Purpose: serial block link wires between host and device
// Assumes: host makes sclk; cs_n low frames one block
// Notes:   device samples mosi and advances miso on rising sclk
`timescale 1ns/100ps
interface sbr_link_if;
   logic sclk;
   logic cs_n;
   logic mosi;
   logic miso;
   modport dev (input sclk, input cs_n, input mosi, output miso);
   modport hst (output sclk, output cs_n, output mosi, input miso);
endinterface : sbr_link_if

// ---- rtl/sbr_sync.sv ----
// Purpose: three-stage level synchroniser
// Assumes: input is a slow level
// Notes:   output moves only when the last two stages agree
`timescale 1ns/100ps
module sbr_sync (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic d,
   output logic      q
);
   logic s1_q, s2_q, s3_q, q_q, q_d;

   // ==========================================================
   // Agreement filter
   always_comb begin
      q_d = (s2_q == s3_q) ? s3_q : q_q;
   end

   // Stage one feeds stage two only
   always_ff @(posedge clk) begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (rst) q_q <= 1'b0;
      else     q_q <= q_d;
   end

   assign q = q_q;
endmodule : sbr_sync

// ---- rtl/sbr_dev.sv ----
// Purpose: device end, interprets command blocks and answers with status
// Assumes: rst held while sclk runs at least four edges
// Notes:   link logic on sclk; the block-done event and the status sampled on it cross to clk
`timescale 1ns/100ps
module sbr_dev
   import sbr_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   sbr_link_if.dev         lnk,
   output logic            blk_done,
   output logic [7:0]      last_status
);
   logic             lrst;
   logic [2:0]       bit_q, bit_d;
   logic [8:0]       idx_q, idx_d;
   logic [6:0]       rx_q, rx_d;
   logic [7:0]       rxb;
   logic [7:0]       tx_q, tx_d;
   logic [7:0]       cmd_q, cmd_d;
   logic [7:0]       hi_q, hi_d;
   logic [7:0]       stat_q, stat_d;
   logic [15:0]      a_q, a_d;
   logic [15:0]      n_q, n_d;
   logic [15:0]      f1_q, f1_d;
   logic [15:0]      f2_q, f2_d;
   logic [15:0]      rptr_q, rptr_d;
   logic [15:0]      wptr_q, wptr_d;
   logic [15:0]      rdw_q, rdw_d;
   logic [15:0]      erra_q, erra_d;
   logic             err_q, err_d;
   logic             xchg_q, xchg_d;
   logic             tog_q, tog_d;
   sbr_phase_t       ph_q, ph_d;
   logic [15:0]      mem [MEM_WORDS];
   logic             mem_we;
   logic [8:0]       mem_wa;
   logic [15:0]      mem_wd;
   logic             last;
   logic [8:0]       k;
   logic [9:0]       map;
   logic             tog_s, tprev_q, done_q, done_d;
   logic [7:0]       lstat_q, lstat_d;

   // ==========================================================
   // Link reset, taken into the sclk domain
   sbr_sync u_rst (
      .clk (lnk.sclk),
      .rst (1'b0),
      .d   (rst),
      .q   (lrst)
   );

   // ==========================================================
   // Byte engine and command execution
   always_comb begin
      bit_d  = bit_q;
      idx_d  = idx_q;
      rx_d   = rx_q;
      tx_d   = tx_q;
      cmd_d  = cmd_q;
      hi_d   = hi_q;
      stat_d = stat_q;
      a_d    = a_q;
      n_d    = n_q;
      f1_d   = f1_q;
      f2_d   = f2_q;
      rptr_d = rptr_q;
      wptr_d = wptr_q;
      rdw_d  = rdw_q;
      erra_d = erra_q;
      err_d  = err_q;
      xchg_d = xchg_q;
      tog_d  = tog_q;
      ph_d   = ph_q;
      mem_we = 1'b0;
      mem_wa = 9'h000;
      mem_wd = 16'h0000;
      last   = 1'b0;
      k      = 9'h000;
      map    = 10'h000;
      rxb    = {rx_q, lnk.mosi};
      if (!lnk.cs_n) begin
         bit_d = bit_q + 3'd1;
         rx_d  = rxb[6:0];
         if (bit_q == 3'd7) begin
            idx_d = idx_q + 9'd1;
            if (ph_q == PH_FIX) begin
               last = (idx_q == 9'(FIX_BYTES - 1));
               case (idx_q)
                  9'd0:    cmd_d = rxb;
                  9'd1:    a_d[15:8] = rxb;
                  9'd2:    a_d[7:0] = rxb;
                  9'd3:    n_d[15:8] = rxb;
                  default: n_d[7:0] = rxb;
               endcase
            end else begin
               last = (idx_q == {n_q[7:0], 1'b0} - 9'd1);
               if (!idx_q[0]) begin
                  hi_d = rxb;
               end else if (xchg_q) begin
                  // Written words land from 0x1001 upward
                  map = addr_map(wptr_q);
                  if (map[9]) begin
                     mem_we = 1'b1;
                     mem_wa = map[8:0];
                     mem_wd = {hi_q, rxb};
                  end else if (!err_d) begin
                     err_d  = 1'b1;
                     erra_d = wptr_q;
                  end
                  wptr_d = wptr_q + 16'h0001;
               end
            end
            if (last && ph_q == PH_FIX) begin
               tog_d = ~tog_q;
               case (cmd_d)
                  CMD_NOP: begin
                     // Status stands, so the host can fetch it
                     stat_d = stat_q;
                  end
                  CMD_RD_WORD: begin
                     map = addr_map(a_d);
                     if (map[9]) begin
                        stat_d = ST_FETCH_OK;
                        f1_d   = ERR_NONE;
                        f2_d   = mem[map[8:0]];
                     end else begin
                        stat_d = ST_FETCH_FAILED;
                        f1_d   = ERR_ADDR;
                        f2_d   = a_d;
                     end
                  end
                  CMD_RD_BULK, CMD_XCHG: begin
                     if (lim_ok(cmd_d, a_d, n_d)) begin
                        ph_d   = PH_VAR;
                        xchg_d = (cmd_d == CMD_XCHG);
                        err_d  = 1'b0;
                        rptr_d = (cmd_d == CMD_XCHG) ? IN_BASE : a_d;
                        wptr_d = OUT_BASE;
                     end else begin
                        // Access skipped, nothing moves
                        stat_d = (cmd_d == CMD_XCHG) ? ST_XCHG_FAILED : ST_FETCH_FAILED;
                        f1_d   = ERR_LEN;
                        f2_d   = a_d;
                     end
                  end
                  default: begin
                     stat_d = ST_FETCH_FAILED;
                     f1_d   = ERR_ACCESS;
                     f2_d   = a_d;
                  end
               endcase
            end else if (last) begin
               // Outcome goes out in the next fixed block
               ph_d = PH_FIX;
               if (xchg_q) stat_d = err_d ? ST_XCHG_FAILED : ST_XCHG_OK;
               else        stat_d = err_d ? ST_FETCH_FAILED : ST_FETCH_OK;
               f1_d = err_d ? ERR_ADDR : ERR_NONE;
               f2_d = err_d ? erra_d : 16'h0000;
            end
            // Prepare the next byte to shift out
            k = last ? 9'h000 : idx_q + 9'd1;
            if (ph_d == PH_FIX) begin
               tx_d = fix_byte(k[2:0], stat_d, f1_d, f2_d);
            end else if (k[0]) begin
               tx_d = rdw_q[7:0];
            end else begin
               map   = addr_map(rptr_d);
               rdw_d = map[9] ? mem[map[8:0]] : 16'h0000;
               if (!map[9] && !err_d) begin
                  err_d  = 1'b1;
                  erra_d = rptr_d;
               end
               rptr_d = rptr_d + 16'h0001;
               tx_d   = rdw_d[15:8];
            end
         end
      end
   end

   // Bit and byte position end with the frame itself
   always_ff @(posedge lnk.sclk or posedge lnk.cs_n) begin
      if (lnk.cs_n) begin
         bit_q <= 3'd0;
         idx_q <= 9'h000;
      end else begin
         bit_q <= bit_d;
         idx_q <= idx_d;
      end
   end

   // Persistent link state
   always_ff @(posedge lnk.sclk) begin
      if (lrst) begin
         rx_q   <= 7'h00;
         tx_q   <= ST_NONE;
         cmd_q  <= CMD_NOP;
         hi_q   <= 8'h00;
         stat_q <= ST_NONE;
         a_q    <= 16'h0000;
         n_q    <= 16'h0000;
         f1_q   <= 16'h0000;
         f2_q   <= 16'h0000;
         rptr_q <= 16'h0000;
         wptr_q <= 16'h0000;
         rdw_q  <= 16'h0000;
         erra_q <= 16'h0000;
         err_q  <= 1'b0;
         xchg_q <= 1'b0;
         tog_q  <= 1'b0;
         ph_q   <= PH_FIX;
      end else begin
         rx_q   <= rx_d;
         tx_q   <= tx_d;
         cmd_q  <= cmd_d;
         hi_q   <= hi_d;
         stat_q <= stat_d;
         a_q    <= a_d;
         n_q    <= n_d;
         f1_q   <= f1_d;
         f2_q   <= f2_d;
         rptr_q <= rptr_d;
         wptr_q <= wptr_d;
         rdw_q  <= rdw_d;
         erra_q <= erra_d;
         err_q  <= err_d;
         xchg_q <= xchg_d;
         tog_q  <= tog_d;
         ph_q   <= ph_d;
      end
   end

   // Register store; cleared so reads never show unknowns
   always_ff @(posedge lnk.sclk) begin
      if (lrst) begin
         for (int i = 0; i < MEM_WORDS; i++) mem[i] <= 16'h0000;
      end else if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end

   // Most significant bit leaves first
   assign lnk.miso = tx_q[3'd7 - bit_q];

   // ==========================================================
   // Block-done event into clk; status is stable for a whole block
   sbr_sync u_done (
      .clk (clk),
      .rst (rst),
      .d   (tog_q),
      .q   (tog_s)
   );

   always_comb begin
      done_d  = tog_s ^ tprev_q;
      lstat_d = done_d ? stat_q : lstat_q;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         tprev_q <= 1'b0;
         done_q  <= 1'b0;
         lstat_q <= ST_NONE;
      end else begin
         tprev_q <= tog_s;
         done_q  <= done_d;
         lstat_q <= lstat_d;
      end
   end

   assign blk_done    = done_q;
   assign last_status = lstat_q;
endmodule : sbr_dev

// ---- rtl/sbr_host.sv ----
// Purpose: host end, sends command blocks and collects answers
// Assumes: user issues the next command only after rsp_valid
// Notes:   sclk runs free from a divider so the device can leave reset
`timescale 1ns/100ps
module sbr_host
   import sbr_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   sbr_link_if.hst          lnk,
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire logic [7:0]  req_cmd,
   input  wire logic [15:0] req_addr,
   input  wire logic [15:0] req_count,
   input  wire logic [15:0] wr_word,
   output logic             wr_take,
   output logic             rsp_valid,
   output logic [7:0]       rsp_status,
   output logic [15:0]      rsp_code,
   output logic [15:0]      rsp_data,
   output logic             rsp_data_ok,
   output logic             rd_valid,
   output logic [15:0]      rd_word,
   output logic             bulk_drop
);
   typedef enum logic {H_IDLE, H_RUN} sbr_hstate_t;
   sbr_hstate_t      st_q, st_d;
   logic [2:0]       div_q, div_d, bit_q, bit_d;
   logic             sclk_q, sclk_d, cs_n_q, cs_n_d, mosi_q, mosi_d;
   logic [8:0]       idx_q, idx_d, nb_q, nb_d;
   logic [7:0]       cmd_q, cmd_d, tx_q, tx_d, rx_q, rx_d;
   logic [15:0]      a_q, a_d, n_q, n_d, wd_q, wd_d, r1_q, r1_d, r2_q, r2_d;
   logic             var_q, var_d, need_q, need_d, vdone_q, vdone_d;
   logic [7:0]       rs_q, rs_d;
   logic             rv_q, rv_d, dv_q, dv_d, drop_q, drop_d, dok_q, dok_d;
   logic             rise, fall, miso_s;
   logic [8:0]       k;

   sbr_sync u_miso (
      .clk (clk),
      .rst (rst),
      .d   (lnk.miso),
      .q   (miso_s)
   );

   // ==========================================================
   // Divider, framing and byte handling
   always_comb begin
      st_d = st_q; bit_d = bit_q; idx_d = idx_q; nb_d = nb_q;
      cs_n_d = cs_n_q; mosi_d = mosi_q; cmd_d = cmd_q; tx_d = tx_q;
      rx_d = rx_q; a_d = a_q; n_d = n_q; wd_d = wd_q; r1_d = r1_q;
      r2_d = r2_q; var_d = var_q; need_d = need_q; vdone_d = vdone_q;
      rs_d = rs_q; dok_d = dok_q;
      rv_d = 1'b0; dv_d = 1'b0; drop_d = 1'b0;
      req_ready = 1'b0; wr_take = 1'b0; k = 9'h000;
      rise   = (div_q == HALF_CYC - 3'd1) && !sclk_q;
      fall   = (div_q == HALF_CYC - 3'd1) && sclk_q;
      div_d  = (div_q == HALF_CYC - 3'd1) ? 3'd0 : div_q + 3'd1;
      sclk_d = (div_q == HALF_CYC - 3'd1) ? ~sclk_q : sclk_q;
      case (st_q)
         H_IDLE: begin
            if (fall && need_q) begin
               // Data block follows its command automatically
               var_d = 1'b1;
               nb_d  = {n_q[7:0], 1'b0};
               tx_d  = 8'h00;
               if (cmd_q == CMD_XCHG) begin
                  wr_take = 1'b1;
                  wd_d    = wr_word;
                  tx_d    = wr_word[15:8];
               end
            end else if (fall && req_valid) begin
               req_ready = 1'b1;
               var_d = 1'b0;
               nb_d  = 9'(FIX_BYTES);
               cmd_d = req_cmd;
               a_d   = req_addr;
               n_d   = req_count;
               tx_d  = req_cmd;
            end
            if (fall && (need_q || req_valid)) begin
               st_d   = H_RUN;
               cs_n_d = 1'b0;
               bit_d  = 3'd0;
               idx_d  = 9'h000;
               mosi_d = tx_d[7];
            end
         end
         default: begin
            if (rise) begin
               rx_d  = {rx_q[6:0], miso_s};
               bit_d = bit_q + 3'd1;
               if (bit_q == 3'd7) begin
                  idx_d = idx_q + 9'd1;
                  k     = idx_q + 9'd1;
                  if (!var_q) begin
                     case (idx_q)
                        9'd0:    rs_d = rx_d;
                        9'd1:    r1_d[15:8] = rx_d;
                        9'd2:    r1_d[7:0] = rx_d;
                        9'd3:    r2_d[15:8] = rx_d;
                        default: r2_d[7:0] = rx_d;
                     endcase
                     if (idx_q == 9'(FIX_BYTES - 1)) begin
                        rv_d    = 1'b1;
                        dok_d   = (rs_d == ST_FETCH_OK);
                        drop_d  = vdone_q && (rs_d != ST_FETCH_OK) && (rs_d != ST_XCHG_OK);
                        vdone_d = 1'b0;
                        need_d  = (cmd_q == CMD_RD_BULK || cmd_q == CMD_XCHG)
                                  && lim_ok(cmd_q, a_q, n_q);
                     end
                     tx_d = fix_byte(k[2:0], cmd_q, a_q, n_q);
                  end else begin
                     if (!idx_q[0]) r1_d[15:8] = rx_d;
                     else begin
                        dv_d = 1'b1;
                        r2_d = {r1_q[15:8], rx_d};
                     end
                     tx_d = 8'h00;
                     if (cmd_q == CMD_XCHG && k != nb_q) begin
                        if (k[0]) tx_d = wd_q[7:0];
                        else begin
                           wr_take = 1'b1;
                           wd_d    = wr_word;
                           tx_d    = wr_word[15:8];
                        end
                     end
                     if (k == nb_q) begin
                        need_d  = 1'b0;
                        vdone_d = 1'b1;
                     end
                  end
               end
            end
            if (fall) begin
               if (idx_q == nb_q) begin
                  st_d   = H_IDLE;
                  cs_n_d = 1'b1;
               end else begin
                  mosi_d = tx_q[3'd7 - bit_q];
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= H_IDLE; div_q <= 3'd0; bit_q <= 3'd0; sclk_q <= 1'b0;
         cs_n_q <= 1'b1; mosi_q <= 1'b0; idx_q <= 9'h000; nb_q <= 9'h000;
         cmd_q <= CMD_NOP; tx_q <= 8'h00; rx_q <= 8'h00; a_q <= 16'h0000;
         n_q <= 16'h0000; wd_q <= 16'h0000; r1_q <= 16'h0000; r2_q <= 16'h0000;
         var_q <= 1'b0; need_q <= 1'b0; vdone_q <= 1'b0; rs_q <= ST_NONE;
         rv_q <= 1'b0; dv_q <= 1'b0; drop_q <= 1'b0; dok_q <= 1'b0;
      end else begin
         st_q <= st_d; div_q <= div_d; bit_q <= bit_d; sclk_q <= sclk_d;
         cs_n_q <= cs_n_d; mosi_q <= mosi_d; idx_q <= idx_d; nb_q <= nb_d;
         cmd_q <= cmd_d; tx_q <= tx_d; rx_q <= rx_d; a_q <= a_d;
         n_q <= n_d; wd_q <= wd_d; r1_q <= r1_d; r2_q <= r2_d;
         var_q <= var_d; need_q <= need_d; vdone_q <= vdone_d; rs_q <= rs_d;
         rv_q <= rv_d; dv_q <= dv_d; drop_q <= drop_d; dok_q <= dok_d;
      end
   end

   assign lnk.sclk    = sclk_q;
   assign lnk.cs_n    = cs_n_q;
   assign lnk.mosi    = mosi_q;
   assign rsp_valid   = rv_q;
   assign rsp_status  = rs_q;
   assign rsp_code    = r1_q;
   assign rsp_data    = r2_q;
   assign rsp_data_ok = dok_q;
   assign rd_valid    = dv_q;
   assign rd_word     = r2_q;
   assign bulk_drop   = drop_q;
endmodule : sbr_host

// ---- tb/sbr_props.sv ----
// Purpose: link checks
// Assumes: clk is 8x sclk
// Notes:   sclk edges seen by sampling on clk
`timescale 1ns/100ps
module sbr_props (
   input wire logic clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso
);
   logic sc_q, cs_q, mi_q, dv_q;
   logic [11:0] len_q;
   logic [15:0] cnt_q;
   logic [39:0] mo_q, ms_q;
   wire rise = sclk & ~sc_q;
   wire fin = cs_n & ~cs_q;
   // ==========
   // Frame tracking; miso taken a clk late, before it moves
   always_ff @(posedge clk) begin
      sc_q <= sclk;
      cs_q <= cs_n;
      mi_q <= miso;
      len_q <= cs_n ? 12'h000 : len_q + 12'(rise);
      if (rise) mo_q <= {mo_q[38:0], mosi};
      if (rise) ms_q <= {ms_q[38:0], mi_q};
      if (fin) cnt_q <= mo_q[15:0];
      if (fin) dv_q <= len_q == 12'h028 && mo_q[39:32] == 8'h20;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ==========
   // Link rules
   AST_FRAME_LEN: assert property (fin |-> len_q == 12'h028 || len_q[3:0] == 4'h0)
      else $error("frame length");
   AST_BULK_LEN: assert property (fin && dv_q |-> len_q == 12'h028 || len_q == {cnt_q[7:0], 4'h0})
      else $error("bulk length");
   AST_BULK_ZERO: assert property (!cs_n && dv_q |-> !mosi)
      else $error("bulk mosi");
   AST_STATUS: assert property (fin && len_q == 12'h028 |-> ms_q[39:32] inside {8'h00, 8'h01, 8'h02, 8'h10, 8'h20})
      else $error("status code");
   AST_GAP: assert property (fin |=> cs_n [*7])
      else $error("frame gap");
   AST_SCLK: assert property (rise |-> ##8 rise)
      else $error("sclk period");
   AST_MOSI: assert property (sclk && sc_q && !cs_n |-> $stable(mosi))
      else $error("mosi moved");
   AST_MISO: assert property (!sclk && !sc_q && !cs_n |-> $stable(miso))
      else $error("miso moved");
   C_BULK: cover property (fin && dv_q && len_q == 12'h800);
   C_FAIL: cover property (fin && len_q == 12'h028 && ms_q[39:32] == 8'h20);
   C_ZERO: cover property (!cs_n && dv_q);
endmodule : sbr_props

// ---- tb/tb_top.sv ----
// Purpose: host and device back to back
// Assumes: device reset outlasts host reset
// Notes:   read data comes from exchange writes
`timescale 1ns/100ps
module tb_top;
   import sbr_pkg::*;
   logic clk = 1'b0, rst = 1'b1, rst_d = 1'b1, req_valid = 1'b0;
   logic req_ready, wr_take, rsp_valid, rsp_data_ok, rd_valid, blk_done, bulk_drop;
   logic [7:0] req_cmd = 8'h00, rsp_status, last_status;
   logic [15:0] req_addr, req_count, widx = 16'h0000, rsp_code, rsp_data, rd_word;
   logic [15:0] rdq[$];
   int checks = 0, err_count = 0;
   wire [15:0] wr_word = 16'hA5C0 + widx;
   sbr_link_if lnk ();
   sbr_dev i_sbr_dev (.clk, .rst(rst_d), .lnk(lnk.dev), .blk_done, .last_status);
   sbr_host i_sbr_host (.clk, .rst, .lnk(lnk.hst), .req_valid, .req_ready, .req_cmd, .req_addr,
      .req_count, .wr_word, .wr_take, .rsp_valid, .rsp_status, .rsp_code, .rsp_data, .rsp_data_ok,
      .rd_valid, .rd_word, .bulk_drop);
   sbr_props i_sbr_props (.clk, .rst(rst_d), .sclk(lnk.sclk), .cs_n(lnk.cs_n), .mosi(lnk.mosi), .miso(lnk.miso));
   initial forever #2 clk = ~clk;
   // Next write word on each take; collect read words
   always @(posedge clk) begin
      if (wr_take) widx <= widx + 16'h0001;
      if (rd_valid) rdq.push_back(rd_word);
   end
   // ==========
   // Helpers
   task automatic chk(input string n, input logic [15:0] s, e);
      checks++;
      if (s !== e) begin
         err_count++;
         $display("mismatch %s exp %h seen %h", n, e, s);
      end
   endtask : chk
   // Bounded waits; a data block may hold ready low long
   task automatic op(input logic [7:0] c, input logic [15:0] a, n);
      @(negedge clk);
      {req_cmd, req_addr, req_count, req_valid} = {c, a, n, 1'b1};
      repeat (20000) if (req_ready !== 1'b1) @(negedge clk);
      // A wait that runs out is a failure, not a silent skip
      if (req_ready !== 1'b1) err_count++;
      @(negedge clk);
      req_valid = 1'b0;
      repeat (900) if (rsp_valid !== 1'b1) @(negedge clk);
      if (rsp_valid !== 1'b1) err_count++;
   endtask : op
   task automatic nop;
      op(CMD_NOP, 16'h0000, 16'h0000);
   endtask : nop
   // ==========
   // Scenarios
   task automatic t_first;
      nop;
      chk("first st", rsp_status, ST_NONE);
      chk("first ok", rsp_data_ok, 1'b0);
   endtask : t_first
   task automatic t_xchg;
      op(CMD_XCHG, 16'h3333, 16'h0002);
      nop;
      chk("xchg st", rsp_status, ST_XCHG_OK);
      chk("xchg taken", widx, 16'h0002);
      op(CMD_XCHG, 16'h0000, 16'h0081);
      nop;
      chk("xchg bad", rsp_status, ST_XCHG_FAILED);
   endtask : t_xchg
   task automatic t_word;
      op(CMD_RD_WORD, 16'h1002, 16'h0000);
      nop;
      chk("word st", rsp_status, ST_FETCH_OK);
      chk("word data", rsp_data, 16'hA5C1);
      op(CMD_RD_WORD, 16'h5000, 16'h0000);
      nop;
      chk("bad addr", rsp_status, ST_FETCH_FAILED);
      chk("bad ok", rsp_data_ok, 1'b0);
      nop;
      chk("nop keeps", rsp_status, ST_FETCH_FAILED);
      // Device side reports the block a few clk after its end
      repeat (16) if (blk_done !== 1'b1) @(negedge clk);
      chk("dev done", blk_done, 1'b1);
      chk("dev status", last_status, ST_FETCH_FAILED);
   endtask : t_word
   // Two legal, then three refused counts
   task automatic t_bulk;
      logic [15:0] ba[5] = '{16'h1001, 16'h1001, 16'h0010, 16'h2001, 16'h1001};
      logic [15:0] bn[5] = '{16'h0002, 16'h0080, 16'h0011, 16'h0011, 16'h0000};
      foreach (ba[i]) begin
         rdq.delete();
         op(CMD_RD_BULK, ba[i], bn[i]);
         nop;
         chk("bulk st", rsp_status, i < 2 ? ST_FETCH_OK : ST_FETCH_FAILED);
         chk("bulk n", 16'(rdq.size()), i < 2 ? bn[i] : 16'h0000);
         if (i > 1) chk("bulk addr", rsp_data, ba[i]);
         chk("bulk keep", bulk_drop, 1'b0);
         if (i < 2) chk("bulk w0", rdq[0], 16'hA5C0);
         if (i < 2) chk("bulk w1", rdq[1], 16'hA5C1);
      end
      // Run off the end of the general area mid block
      rdq.delete();
      op(CMD_RD_BULK, 16'h0038, 16'h0010);
      nop;
      chk("bulk err", rsp_status, ST_FETCH_FAILED);
      chk("bulk code", rsp_code, ERR_ADDR);
      chk("bulk fail", rsp_data, GEN_WORDS);
      chk("bulk drop", bulk_drop, 1'b1);
      chk("bulk cnt", 16'(rdq.size()), 16'h0010);
   endtask : t_bulk
   task automatic end_of_test;
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (12) @(negedge clk);
      rst = 1'b0;
      // Device reset must span several sclk edges to pass its synchroniser
      repeat (64) @(negedge clk);
      rst_d = 1'b0;
      repeat (48) @(negedge clk);
      t_first;
      t_xchg;
      t_word;
      t_bulk;
      end_of_test;
   end
   // Watchdog well past the expected run
   initial begin
      #200000;
      err_count++;
      end_of_test;
   end
endmodule : tb_top
